// ===== src/rbq_pkg.sv
// package: constants and carrier types for the record biquad bank and mixer
package rbq_pkg;
  // ----------------------------------------------------------------
  // register addressing: {page[3:0], reg[6:0]}
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam logic [3:0] PAGE_CFG = 4'h0; // configuration page
  localparam logic [3:0] PAGE_BQ_LO = 4'h8; // sections 1 to 6
  localparam logic [3:0] PAGE_BQ_HI = 4'h9; // sections 7 to 12
  localparam logic [3:0] PAGE_MIX = 4'hC; // mixer coefficients
  localparam logic [6:0] REG_ALLOC = 7'h72; // allocation field lives here
  localparam logic [6:0] REG_CTRL = 7'h73; // bank, two-channel, summing
  localparam logic [6:0] REG_STAT = 7'h74; // read-only status
  localparam logic [6:0] REG_COEF_BASE = 7'h08; // first coefficient byte
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int ALLOC_LSB = 2; // allocation field is bits 3:2
  localparam logic [1:0] ALLOC_RESET = 2'h2; // two sections per channel
  localparam int CTRL_BANK = 0; // bank-switch toggle bit
  localparam int CTRL_TWOCH = 1; // two-channel bank mode
  localparam int CTRL_SUM = 2; // summing mode
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4; // record channels
  localparam int NUM_SEC = 12; // biquad sections
  localparam int MAX_STAGE = 3; // sections per channel at most
  localparam int SEC_BYTES = 20; // five 32-bit coefficients
  localparam int SEC_PER_PAGE = 6;
  localparam int BQ_BYTES = NUM_SEC * SEC_BYTES;
  localparam int MIX_BYTES = NUM_CH * NUM_CH * 4;
  localparam int LAST_STEP = NUM_SEC - 1; // last engine step per frame
  localparam int FIFO_DEPTH = 32;
  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  localparam int FRAC = 31; // coefficient scale is 2^31
  localparam logic [7:0] COEF_ONE_MSB = 8'h7F; // top byte of +1 code
  localparam logic [7:0] COEF_ONE_LOW = 8'hFF; // lower bytes of +1 code
  localparam logic signed [31:0] SAMPLE_MAX = 32'sh7FFFFFFF;
  localparam logic signed [31:0] SAMPLE_MIN = 32'sh80000000;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [NUM_CH-1:0][31:0] rbq_frame_t; // one sample per channel
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rbq_regreq_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILT = 2'b01,
    ST_MIX = 2'b11,
    ST_PUSH = 2'b10
  } rbq_state_t;
endpackage

// ===== src/rbq_biquad_mixer.sv
// record biquad bank, channel summer/mixer, output fifo
`timescale 1ns/10ps

// ------------------------------------------------------------------
// fifo with valid/ready on both sides
// ------------------------------------------------------------------
module rbq_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [PW-1:0] wrPtr; // next slot to fill
  logic [PW-1:0] rdPtr; // oldest entry
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  assign inReady = (level != (PW+1)'(DEPTH));
  assign outValid = (level != '0);
  assign outData = mem[rdPtr];
  // pointer and level bookkeeping
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'b1;
      end
      level <= level + (PW+1)'(doWrite) - (PW+1)'(doRead);
    end
  end
  // data write
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

// ------------------------------------------------------------------
// top: biquad engine, mixer, register port
// ------------------------------------------------------------------
module rbq_biquad_mixer #(
  parameter int FIFO_DEPTH = rbq_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire rbq_pkg::rbq_regreq_t regReq,
  output logic [7:0] regRdata,
  // samples from the decimators
  input wire logic inValid,
  output logic inReady,
  input wire rbq_pkg::rbq_frame_t inData,
  // samples toward the serial interface
  output logic outValid,
  input wire logic outReady,
  output rbq_pkg::rbq_frame_t outData
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic signed [67:0] SAMPLE_MAX_W = 68'(rbq_pkg::SAMPLE_MAX);
  localparam logic signed [67:0] SAMPLE_MIN_W = 68'(rbq_pkg::SAMPLE_MIN);
  // clamp a wide result into the sample range
  function automatic logic signed [31:0] sat32(input logic signed [67:0] v);
    if (v > 68'(SAMPLE_MAX_W)) begin
      return rbq_pkg::SAMPLE_MAX;
    end else if (v < 68'(SAMPLE_MIN_W)) begin
      return rbq_pkg::SAMPLE_MIN;
    end
    return v[31:0];
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] coefMem [rbq_pkg::BQ_BYTES]; // biquad coefficient bytes
  logic [7:0] mixMem [rbq_pkg::MIX_BYTES]; // mixer coefficient bytes
  logic [1:0] alloc; // sections per channel
  logic bankSel; // software bank toggle
  logic twoCh; // two-channel bank mode
  logic sumMode; // equal-weight summing
  logic activeBank; // bank in use for this frame

  // address decode
  wire [3:0] page = regReq.addr[10:7];
  wire [6:0] regNo = regReq.addr[6:0];
  wire inCoef = (regNo >= rbq_pkg::REG_COEF_BASE);
  wire [7:0] coefOff = 8'(regNo - rbq_pkg::REG_COEF_BASE);
  wire hitBqLo = (page == rbq_pkg::PAGE_BQ_LO) && inCoef;
  wire hitBqHi = (page == rbq_pkg::PAGE_BQ_HI) && inCoef;
  wire hitMix = (page == rbq_pkg::PAGE_MIX) && inCoef
    && (coefOff < 8'(rbq_pkg::MIX_BYTES));
  // biquad byte index: page 9 continues after page 8
  wire [7:0] bqIdx = hitBqHi ? 8'(coefOff + 8'(rbq_pkg::SEC_PER_PAGE * rbq_pkg::SEC_BYTES))
    : coefOff;
  wire hitCfg = (page == rbq_pkg::PAGE_CFG);
  wire wrAlloc = regReq.wr && hitCfg && (regNo == rbq_pkg::REG_ALLOC);
  wire wrCtrl = regReq.wr && hitCfg && (regNo == rbq_pkg::REG_CTRL);

  // coefficient bytes, one flip-flop group per byte
  genvar gb;
  generate
    for (gb = 0; gb < rbq_pkg::BQ_BYTES; gb++) begin : g_bq
      // top byte of N0 is 7F, next three FF: unity pass-through
      localparam logic [7:0] RST = ((gb % rbq_pkg::SEC_BYTES) == 0) ? rbq_pkg::COEF_ONE_MSB
        : ((gb % rbq_pkg::SEC_BYTES) < 4) ? rbq_pkg::COEF_ONE_LOW : 8'h00;
      always_ff @(posedge clk) begin
        if (!resetn) begin
          coefMem[gb] <= RST;
        end else if (regReq.wr && (hitBqLo || hitBqHi) && (bqIdx == 8'(gb))) begin
          coefMem[gb] <= regReq.wdata;
        end
      end
    end
    for (gb = 0; gb < rbq_pkg::MIX_BYTES; gb++) begin : g_mix
      // diagonal gains reset to +1 so outputs follow inputs
      localparam bit DIAG = ((gb / 4) / rbq_pkg::NUM_CH) == ((gb / 4) % rbq_pkg::NUM_CH);
      localparam logic [7:0] RST = !DIAG ? 8'h00
        : ((gb % 4) == 0) ? rbq_pkg::COEF_ONE_MSB : rbq_pkg::COEF_ONE_LOW;
      always_ff @(posedge clk) begin
        if (!resetn) begin
          mixMem[gb] <= RST;
        end else if (regReq.wr && hitMix && (coefOff == 8'(gb))) begin
          mixMem[gb] <= regReq.wdata;
        end
      end
    end
  endgenerate

  // control registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alloc <= rbq_pkg::ALLOC_RESET;
      bankSel <= 1'b0;
      twoCh <= 1'b0;
      sumMode <= 1'b0;
    end else begin
      if (wrAlloc) begin
        alloc <= regReq.wdata[rbq_pkg::ALLOC_LSB +: 2];
      end
      if (wrCtrl) begin
        bankSel <= regReq.wdata[rbq_pkg::CTRL_BANK];
        twoCh <= regReq.wdata[rbq_pkg::CTRL_TWOCH];
        sumMode <= regReq.wdata[rbq_pkg::CTRL_SUM];
      end
    end
  end

  // ----------------------------------------------------------------
  // engine sequencing
  // ----------------------------------------------------------------
  rbq_pkg::rbq_state_t state;
  rbq_pkg::rbq_state_t next_state;
  logic [3:0] stepIdx; // stage in [3:2], channel in [1:0]
  logic [$clog2(FIFO_DEPTH):0] fifoLevel; // same width as the fifo's level port
  logic fifoInReady;
  wire [1:0] stage = stepIdx[3:2];
  wire [1:0] chan = stepIdx[1:0];
  // two-channel mode: channels 1-2 only, bank 1 uses slots 3-4
  wire [1:0] slot = (twoCh && activeBank) ? (chan | 2'b10) : chan;
  wire [3:0] secIdx = {stage, slot};
  wire stageOn = (stage < alloc) && !(twoCh && chan[1]);
  wire frameTaken = (state == rbq_pkg::ST_IDLE) && inValid;

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      rbq_pkg::ST_IDLE: begin
        if (inValid) begin
          next_state = rbq_pkg::ST_FILT;
        end
      end
      rbq_pkg::ST_FILT: begin
        if (stepIdx == 4'(rbq_pkg::LAST_STEP)) begin
          next_state = rbq_pkg::ST_MIX;
        end
      end
      rbq_pkg::ST_MIX: next_state = rbq_pkg::ST_PUSH;
      rbq_pkg::ST_PUSH: begin
        if (fifoInReady) begin
          next_state = rbq_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // state, step counter, bank latch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= rbq_pkg::ST_IDLE;
      stepIdx <= '0;
      inReady <= 1'b1;
      activeBank <= 1'b0;
    end else begin
      state <= next_state;
      inReady <= (next_state == rbq_pkg::ST_IDLE);
      stepIdx <= (state == rbq_pkg::ST_FILT) ? stepIdx + 4'h1 : 4'h0;
      if (frameTaken) begin
        activeBank <= bankSel; // switch only between frames
      end
    end
  end

  // ----------------------------------------------------------------
  // biquad datapath, one section per cycle
  // ----------------------------------------------------------------
  logic signed [31:0] work [rbq_pkg::NUM_CH]; // samples in flight
  logic signed [31:0] x1 [rbq_pkg::NUM_SEC]; // per-section history
  logic signed [31:0] x2 [rbq_pkg::NUM_SEC];
  logic signed [31:0] y1 [rbq_pkg::NUM_SEC];
  logic signed [31:0] y2 [rbq_pkg::NUM_SEC];
  logic signed [31:0] cf [5]; // N0 N1 N2 D1 D2 of current section
  logic signed [67:0] acc;
  logic signed [31:0] yq;

  // fetch coefficients: four bytes each, high byte first
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      cf[k] = {coefMem[int'(secIdx) * rbq_pkg::SEC_BYTES + k * 4],
        coefMem[int'(secIdx) * rbq_pkg::SEC_BYTES + k * 4 + 1],
        coefMem[int'(secIdx) * rbq_pkg::SEC_BYTES + k * 4 + 2],
        coefMem[int'(secIdx) * rbq_pkg::SEC_BYTES + k * 4 + 3]};
    end
  end

  // feedforward plus feedback, N1 and D1 doubled, scaled by 2^31
  assign acc = (68'(cf[0]) * 68'(work[chan])) + ((68'(cf[1]) * 68'(x1[secIdx])) <<< 1)
    + (68'(cf[2]) * 68'(x2[secIdx])) + ((68'(cf[3]) * 68'(y1[secIdx])) <<< 1)
    + (68'(cf[4]) * 68'(y2[secIdx]));
  assign yq = sat32(acc >>> rbq_pkg::FRAC);

  // history and working samples
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int s = 0; s < rbq_pkg::NUM_SEC; s++) begin
        x1[s] <= '0;
        x2[s] <= '0;
        y1[s] <= '0;
        y2[s] <= '0;
      end
      for (int c = 0; c < rbq_pkg::NUM_CH; c++) begin
        work[c] <= '0;
      end
    end else if (frameTaken) begin
      for (int c = 0; c < rbq_pkg::NUM_CH; c++) begin
        work[c] <= inData[c];
      end
    end else if ((state == rbq_pkg::ST_FILT) && stageOn) begin
      x2[secIdx] <= x1[secIdx];
      x1[secIdx] <= work[chan];
      y2[secIdx] <= y1[secIdx];
      y1[secIdx] <= yq;
      work[chan] <= yq; // cascade into the next stage
    end
  end

  // ----------------------------------------------------------------
  // summer and mixers
  // ----------------------------------------------------------------
  wire rbq_pkg::rbq_frame_t mixOut; // one driver per output lane
  rbq_pkg::rbq_frame_t mixReg;
  logic signed [33:0] chanSum;
  logic signed [67:0] macc [rbq_pkg::NUM_CH];
  assign chanSum = 34'(work[0]) + 34'(work[1]) + 34'(work[2]) + 34'(work[3]);

  genvar go;
  generate
    for (go = 0; go < rbq_pkg::NUM_CH; go++) begin : g_mixer
      // weighted sum of all inputs for output go
      always_comb begin
        macc[go] = '0;
        for (int i = 0; i < rbq_pkg::NUM_CH; i++) begin
          macc[go] = macc[go] + 68'($signed({mixMem[(go * rbq_pkg::NUM_CH + i) * 4],
            mixMem[(go * rbq_pkg::NUM_CH + i) * 4 + 1],
            mixMem[(go * rbq_pkg::NUM_CH + i) * 4 + 2],
            mixMem[(go * rbq_pkg::NUM_CH + i) * 4 + 3]})) * 68'(work[i]);
        end
      end
      // summing mode averages, otherwise mixer result saturated
      assign mixOut[go] = sumMode ? chanSum[33:2]
        : sat32(macc[go] >>> rbq_pkg::FRAC);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mixReg <= '0;
    end else if (state == rbq_pkg::ST_MIX) begin
      mixReg <= mixOut;
    end
  end

  // ----------------------------------------------------------------
  // fifo and output register
  // ----------------------------------------------------------------
  logic fifoOutValid;
  rbq_pkg::rbq_frame_t fifoOutData;
  wire takeFromFifo = !outValid || outReady;
  rbq_fifo #(
    .WIDTH($bits(rbq_pkg::rbq_frame_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(state == rbq_pkg::ST_PUSH),
    .inReady(fifoInReady),
    .inData(mixReg),
    .outValid(fifoOutValid),
    .outReady(takeFromFifo),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (takeFromFifo) begin
      outValid <= fifoOutValid;
      outData <= fifoOutData;
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [7:0] cfgRd = (regNo == rbq_pkg::REG_ALLOC) ? 8'({alloc, 2'b00})
    : (regNo == rbq_pkg::REG_CTRL) ? {5'h00, sumMode, twoCh, bankSel}
    : (regNo == rbq_pkg::REG_STAT) ? {activeBank, 7'(fifoLevel)} : 8'h00;
  wire [7:0] rdMux = hitCfg ? cfgRd
    : (hitBqLo || hitBqHi) ? coefMem[bqIdx]
    : hitMix ? mixMem[coefOff[5:0]] : 8'h00;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regReq.rd ? rdMux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_filt_length: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state == rbq_pkg::ST_FILT) |-> (stepIdx == 4'h0) ##11
    (state == rbq_pkg::ST_FILT && stepIdx == 4'hB) ##1 (state == rbq_pkg::ST_MIX))
    else $error("filter pass not twelve steps");
  a_section_range: assert property (@(posedge clk) disable iff (!resetn)
    (state == rbq_pkg::ST_FILT && stageOn) |-> secIdx < 4'hC)
    else $error("section index out of range");
  a_alloc_zero: assert property (@(posedge clk) disable iff (!resetn)
    (state == rbq_pkg::ST_FILT && alloc == 2'h0 && chan == 2'h0) |=> work[0] == $past(work[0]))
    else $error("biquad active with allocation zero");
  a_alloc_one: assert property (@(posedge clk) disable iff (!resetn)
    (alloc == 2'h1 && stage != 2'h0) |-> !stageOn) else $error("extra section active");
  a_alloc_two: assert property (@(posedge clk) disable iff (!resetn)
    (state == rbq_pkg::ST_FILT && alloc == 2'h2 && !twoCh && stage == 2'h1)
    |-> stageOn && secIdx == 4'(4 + chan)) else $error("second stage section wrong");
  a_alloc_three: assert property (@(posedge clk) disable iff (!resetn)
    (state == rbq_pkg::ST_FILT && alloc == 2'h3 && !twoCh && stage == 2'h2)
    |-> stageOn && secIdx == 4'(8 + chan)) else $error("third stage section wrong");
  a_bank_pick: assert property (@(posedge clk) disable iff (!resetn)
    (state == rbq_pkg::ST_FILT && twoCh && stageOn) |-> secIdx[1] == activeBank)
    else $error("bank not honoured");
  a_mix_push: assert property (@(posedge clk) disable iff (!resetn)
    (state == rbq_pkg::ST_MIX) |=> (state == rbq_pkg::ST_PUSH) && mixReg == $past(mixOut))
    else $error("mixer result not captured");
  a_sum_equal: assert property (@(posedge clk) disable iff (!resetn)
    (state == rbq_pkg::ST_MIX && sumMode) |=> mixReg[0] == mixReg[3])
    else $error("summing outputs differ");
  a_read_alloc: assert property (@(posedge clk) disable iff (!resetn)
    (regReq.rd && hitCfg && regNo == rbq_pkg::REG_ALLOC && !wrAlloc)
    |=> regRdata[3:2] == alloc) else $error("allocation readback wrong");
endmodule

// ===== tb/rbq_biquad_mixer_test.sv
// self-checking bench for the record biquad bank and channel mixer
`timescale 1ns/10ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin errorCnt++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end

module rbq_biquad_mixer_test;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic clk = 1'b0; // 125 MHz
  logic resetn = 1'b0; // synchronous, active low
  rbq_pkg::rbq_regreq_t regReq = '0; // register request
  logic [7:0] regRdata; // read data, one cycle after the strobe
  logic inValid = 1'b0;
  logic inReady;
  rbq_pkg::rbq_frame_t inData = '0;
  logic outValid;
  logic outReady = 1'b1; // sink normally never stalls
  rbq_pkg::rbq_frame_t outData;
  rbq_pkg::rbq_frame_t got; // last frame drained
  int errorCnt = 0;
  int samplesChecked = 0;
  int cycles = 0; // watchdog count
  int taken = 0; // frames accepted while the sink stalls
  logic ok;
  localparam logic [10:0] aAlloc = 11'h072; // allocation field register
  localparam logic [10:0] aCtrl = 11'h073; // bank, two-channel, summing
  localparam logic [10:0] aStat = 11'h074; // bank and fifo level
  // one ordinary case: allocation, sample on every channel, expected sample
  typedef struct {logic [1:0] al; logic [31:0] x; logic [31:0] y;} rbq_row_t;
  rbq_row_t rows [6] = '{'{2'h0, 32'h00000100, 32'h000000FF},
    '{2'h1, 32'h00000100, 32'h000000FE}, '{2'h2, 32'h00000100, 32'h000000FD},
    '{2'h3, 32'h00000100, 32'h000000FC}, '{2'h3, 32'hFFFFFF00, 32'hFFFFFF00},
    '{2'h2, 32'h7FFFFFFF, 32'h7FFFFFFC}};

  rbq_biquad_mixer rbq_biquad_mixer_inst (.clk(clk), .resetn(resetn), .regReq(regReq),
    .regRdata(regRdata), .inValid(inValid), .inReady(inReady), .inData(inData),
    .outValid(outValid), .outReady(outReady), .outData(outData));

  // clock and watchdog
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      closeOut();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // verdict and end of run
  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // reset held for sixteen edges
  task automatic doReset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
  endtask
  // one-cycle write strobe
  task automatic wr8(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq <= '0;
  endtask
  // one-cycle read strobe, data looked at in the following cycle
  task automatic rdChk(input logic [10:0] a, input logic [7:0] e);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    #1;
    `CHK("regRdata", e, regRdata)
  endtask
  // a 32-bit value as four bytes, most significant first
  task automatic coef(input logic [3:0] pg, input logic [6:0] r, input logic [31:0] v);
    for (int k = 0; k < 4; k++) begin
      wr8({pg, r + 7'(k)}, v[31 - 8 * k -: 8]);
    end
  endtask
  // section s (1..12), coefficient j in order N0, N1, N2, D1, D2
  task automatic sec(input int s, input int j, input logic [31:0] v);
    coef((s <= 6) ? 4'h8 : 4'h9, 7'(8 + ((s - 1) % 6) * 20 + j * 4), v);
  endtask
  // mixer gain from input i to output o
  task automatic mix(input int o, input int i, input logic [31:0] v);
    coef(4'hC, 7'(8 + (o * 4 + i) * 4), v);
  endtask
  function automatic rbq_pkg::rbq_frame_t fr4(input logic [31:0] a, b, c, d);
    return {d, c, b, a};
  endfunction
  // offer a frame, held until taken or lim cycles pass
  task automatic send(input rbq_pkg::rbq_frame_t f, input int lim, output logic acc);
    @(posedge clk);
    inValid <= 1'b1;
    inData <= f;
    acc = 1'b0;
    for (int n = 0; n < lim && !acc; n++) begin
      #1 acc = (inReady === 1'b1);
      @(posedge clk);
    end
    inValid <= 1'b0;
  endtask
  // collect the next output frame, bounded wait
  task automatic fetch(output rbq_pkg::rbq_frame_t f);
    f = 'x;
    for (int n = 0; n < 100; n++) begin
      #1;
      if (outValid === 1'b1 && outReady === 1'b1) begin
        f = outData;
        @(posedge clk);
        break;
      end
      @(posedge clk);
    end
  endtask
  // one frame through and compared
  task automatic frameChk(input rbq_pkg::rbq_frame_t f, input rbq_pkg::rbq_frame_t e);
    send(f, 40, ok);
    fetch(got);
    `CHK("outData", e, got)
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    doReset();
    #1;
    `CHK("inReady", 1'b1, inReady)
    `CHK("outValid", 1'b0, outValid)
    // reset values and register map
    rdChk(aAlloc, 8'h08);
    rdChk(11'h408, 8'h7F);
    rdChk(11'h46C, 8'h7F);
    rdChk(11'h47F, 8'h00);
    rdChk(11'h608, 8'h7F);
    rdChk(11'h60C, 8'h00);
    wr8(11'h780, 8'hA5);
    rdChk(11'h780, 8'h00);
    wr8(aAlloc, 8'hFF);
    rdChk(aAlloc, 8'h0C);
    $display("done: reset and registers");
    // ordinary cases from the table
    for (int r = 0; r < 6; r++) begin
      wr8(aAlloc, {4'h0, rows[r].al, 2'b00});
      frameChk(fr4(rows[r].x, rows[r].x, rows[r].x, rows[r].x),
        fr4(rows[r].y, rows[r].y, rows[r].y, rows[r].y));
    end
    $display("done: table");
    // sections 5 and 12 silenced show which channel each serves
    sec(5, 0, 32'h00000000);
    sec(12, 0, 32'h00000000);
    wr8(aAlloc, 8'h04);
    frameChk(fr4(256, 256, 256, 256), fr4(254, 254, 254, 254));
    wr8(aAlloc, 8'h08);
    frameChk(fr4(256, 256, 256, 256), fr4(0, 253, 253, 253));
    wr8(aAlloc, 8'h0C);
    frameChk(fr4(256, 256, 256, 256), fr4(0, 252, 252, 0));
    sec(5, 0, 32'h7FFFFFFF);
    sec(12, 0, 32'h7FFFFFFF);
    $display("done: allocation");
    // delayed feedforward and feedback taps, doubled
    wr8(aAlloc, 8'h04);
    sec(1, 0, 32'h00000000);
    sec(1, 1, 32'h40000000);
    frameChk(fr4(256, 256, 256, 256), fr4(255, 254, 254, 254));
    frameChk(fr4(768, 768, 768, 768), fr4(255, 766, 766, 766));
    frameChk(fr4(0, 0, 0, 0), fr4(767, 0, 0, 0));
    sec(1, 1, 32'h00000000);
    sec(1, 3, 32'h40000000);
    frameChk(fr4(0, 0, 0, 0), fr4(767, 0, 0, 0));
    sec(1, 3, 32'h00000000);
    sec(1, 0, 32'h7FFFFFFF);
    $display("done: recursion");
    // mixer gains, zero gain and saturation both ways
    wr8(aAlloc, 8'h00);
    mix(0, 1, 32'h7FFFFFFF);
    mix(3, 3, 32'h00000000);
    frameChk(fr4(256, 512, 0, 1024), fr4(767, 511, 0, 0));
    frameChk(fr4(32'h7FFFFFFF, 32'h7FFFFFFF, 0, 0),
      fr4(32'h7FFFFFFF, 32'h7FFFFFFE, 0, 0));
    frameChk(fr4(32'h80000000, 32'h80000000, 0, 0),
      fr4(32'h80000000, 32'h80000001, 0, 0));
    mix(0, 1, 32'h00000000);
    mix(3, 3, 32'h7FFFFFFF);
    // summing mode, equal weight
    wr8(aCtrl, 8'h04);
    frameChk(fr4(256, 512, 768, 1024), fr4(640, 640, 640, 640));
    wr8(aCtrl, 8'h00);
    $display("done: mixer and summing");
    // two-channel bank switching without power-down
    wr8(aAlloc, 8'h04);
    wr8(aCtrl, 8'h02);
    sec(3, 0, 32'h00000000);
    frameChk(fr4(256, 256, 256, 256), fr4(254, 254, 255, 255));
    rdChk(aStat, 8'h00);
    wr8(aCtrl, 8'h03);
    frameChk(fr4(256, 256, 256, 256), fr4(0, 254, 255, 255));
    rdChk(aStat, 8'h80);
    wr8(aCtrl, 8'h02);
    frameChk(fr4(256, 256, 256, 256), fr4(254, 254, 255, 255));
    sec(3, 0, 32'h7FFFFFFF);
    wr8(aCtrl, 8'h00);
    $display("done: bank switch");
    // fill the buffer against a stalled sink, then drain in order
    wr8(aAlloc, 8'h00);
    @(posedge clk);
    outReady <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      send(fr4(~i, ~i, ~i, ~i), 40, ok);
      if (!ok) break;
      taken++;
    end
    `CHK("refused", 1'b1, taken >= 32 && taken < 40)
    rdChk(aStat, 8'h20);
    @(posedge clk);
    outReady <= 1'b1;
    for (int i = 0; i < taken; i++) begin
      fetch(got);
      `CHK("drained", fr4(~i, ~i, ~i, ~i), got)
    end
    rdChk(aStat, 8'h00);
    `CHK("outValid", 1'b0, outValid)
    $display("done: buffer");
    // second reset in mid-run restores the default allocation
    wr8(aAlloc, 8'h04);
    doReset();
    #1;
    `CHK("inReady", 1'b1, inReady)
    `CHK("outValid", 1'b0, outValid)
    `CHK("regRdata", 8'h00, regRdata)
    rdChk(aAlloc, 8'h08);
    $display("done: second reset");
    closeOut();
  end
endmodule
